// [rtl/sar_adc_pin_ref_gpo_ctrl.v]
// Converter control top: CPU registers, reference and pin steering, output drivers, pen status
//
// What this block does
// [RL1] Reference bit picks supply or bandgap reference
// [RL2] Touch mode overrides the reference select bit
// [RL3] Software writes zero to reserved bit five
// [RL4] Touch mode steers references to driven pins
// [RL5] Supply measure bit closes channel three switch
// [RL6] Supply measurement needs bandgap reference and halving
// [RL7] Ground bit grounds channel zero, divides channel one
// [RL8] Halving samples half the capacitor array
// [RL9] Stylus status shows pen contact
// [RL10] Stylus enable gates pen onto interrupt line
// [RL11] Enable bits switch analog pin drivers on
// [RL12] Level bits drive enabled pins high or low
// [RL13] Software keeps converter clock at most 2MHz
// [RL14] Software starts conversion with start and channel
// [RL15] Busy rises after a start request
// [RL16] Software reads busy back before waiting
// [RL17] Completion clears busy; in single mode it enters standby and clears start one clock later
// [RL18] Result holds channel and value after completion
// [RL19] Busy rises three converter clocks after start
// [RL20] Converter clock is system clock over divider+1
// [RL21] Level select picks 0.8V or 1V bandgap
// [RL22] Touch references follow the enabled drive pair
`include "sar_adc_regs.vh"

module sar_adc_pin_ref_gpo_ctrl (
  input wire clk,
  input wire resetn,
  input wire [15:0] addr,
  input wire wrEn,
  input wire rdEn,
  input wire [15:0] wrData,
  output reg [15:0] rdData_r,
  input wire compHigh,
  input wire penDetect,
  output wire sarTick,
  output wire converterStandby,
  output wire sampleEnable,
  output wire halfArraySample,
  output wire [2:0] muxChannel,
  output wire muxChannelValid,
  output wire [9:0] trialCode,
  output reg vrefFromSupply_r,
  output reg vrefFromBandgap_r,
  output reg bandgapLevel1V_r,
  output reg vrefFromPins_r,
  output reg [1:0] vrefPosPin_r,
  output reg [1:0] vrefNegPin_r,
  output reg supplyMeasureSwitch_r,
  output reg channel0Ground_r,
  output reg channel1Divider_r,
  output reg biasPowerUp_r,
  output reg analogPowerUp_r,
  output reg refBufferEnable_r,
  output reg [3:0] pinOut_r,
  output reg [3:0] pinOe_r,
  output reg stylusIrq_r,
  output wire clkDivTooFast
);

  // Priority pick of the lowest pin in a mask, with a found flag on top
  function [2:0] pickPin;
    input [3:0] mask;
    begin
      if (mask[0])
        pickPin = 3'h4;
      else if (mask[1])
        pickPin = 3'h5;
      else if (mask[2])
        pickPin = 3'h6;
      else if (mask[3])
        pickPin = 3'h7;
      else
        pickPin = 3'h0;
    end
  endfunction

  reg conversionStart_r;
  reg [2:0] channelSelect_r;
  reg multiChannel_r;
  reg singleConv_r;
  reg [`CLK_DIV_MSB:0] converterClockDivider_r;
  reg statusMask_r;
  reg bandgapLevelSelect_r;
  reg refSupplySelect_r;
  reg touchPanelEnable_r;
  reg supplyMeasureEnable_r;
  reg channel0GroundEnable_r;
  reg halfMode_r;
  reg stylusIrqEnable_r;
  reg [3:0] driverEnable_r;
  reg [3:0] driveLevel_r;
  reg stylusDetectStatus_r;

  wire conversionBusy;
  wire clearStart;
  wire sampling;
  wire [2:0] activeChan;
  wire [2:0] convertedChannel;
  wire [9:0] conversionResult;

  wire wrCtrl = wrEn && (addr == `ADDR_CONV_CTRL);
  wire wrClk = wrEn && (addr == `ADDR_CLK_CTRL);
  wire wrRefPin = wrEn && (addr == `ADDR_REF_PIN);
  wire wrPinOut = wrEn && (addr == `ADDR_PIN_OUT);

  wire [3:0] highMask = driverEnable_r & driveLevel_r;
  wire [3:0] lowMask = driverEnable_r & ~driveLevel_r;
  wire [2:0] posPick = pickPin(highMask);
  wire [2:0] negPick = pickPin(lowMask);
  wire touchAxisFound = posPick[2] && negPick[2];

  sar_clk_div u_clk_div (
    .clk(clk),
    .resetn(resetn),
    .divider(converterClockDivider_r),
    .sarTick_r(sarTick)
  );

  sar_conv_seq u_conv_seq (
    .clk(clk),
    .resetn(resetn),
    .sarTick(sarTick),
    .startReq(conversionStart_r),
    .singleMode(singleConv_r),
    .multiCh(multiChannel_r),
    .channel_select(channelSelect_r),
    .compHigh(compHigh),
    .busy_r(conversionBusy),
    .clearStart_r(clearStart),
    .sampling_r(sampling),
    .standby_r(converterStandby),
    .activeChan_r(activeChan),
    .trial_r(trialCode),
    .resultChan_r(convertedChannel),
    .resultData_r(conversionResult)
  );

  assign sampleEnable = sampling;
  assign halfArraySample = sampling && halfMode_r; // [RL8]
  assign muxChannel = activeChan;
  assign muxChannelValid = !converterStandby && (activeChan <= 3'h5);
  assign clkDivTooFast = converterClockDivider_r < `MIN_CLK_DIV;

  // Conversion control; a software write wins over the completion clear
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      conversionStart_r <= 1'b0;
      channelSelect_r <= `RST_CHANNEL_SELECT;
      multiChannel_r <= 1'b0;
      singleConv_r <= 1'b0;
    end
    else if (wrCtrl)
    begin
      conversionStart_r <= wrData[`CTRL_START_BIT];
      channelSelect_r <= wrData[`CTRL_CHANNEL_SELECT_MSB:`CTRL_CHANNEL_SELECT_LSB];
      multiChannel_r <= wrData[`CTRL_MULTI_BIT];
      singleConv_r <= wrData[`CTRL_SINGLE_BIT];
    end
    else if (clearStart)
    begin
      conversionStart_r <= 1'b0; // [RL17]
    end
  end

  always @(posedge clk)
  begin
    if (!resetn)
    begin
      converterClockDivider_r <= `RST_CLK_DIV;
    end
    else if (wrClk)
    begin
      converterClockDivider_r <= wrData[`CLK_DIV_MSB:0]; // [RL20]
    end
  end

  // Reference and pin control register; the reserved bit is not stored
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      statusMask_r <= 1'b0;
      biasPowerUp_r <= 1'b0;
      analogPowerUp_r <= 1'b0;
      refBufferEnable_r <= 1'b0;
      bandgapLevelSelect_r <= 1'b0;
      refSupplySelect_r <= 1'b0;
      touchPanelEnable_r <= 1'b0;
      supplyMeasureEnable_r <= 1'b0;
      channel0GroundEnable_r <= 1'b0;
      halfMode_r <= 1'b0;
    end
    else if (wrRefPin)
    begin
      statusMask_r <= wrData[`PIN_STATUSMASK_BIT];
      biasPowerUp_r <= wrData[`PIN_BIAS_BIT];
      analogPowerUp_r <= wrData[`PIN_PWR_BIT];
      refBufferEnable_r <= wrData[`PIN_REFBUF_BIT];
      bandgapLevelSelect_r <= wrData[`PIN_LVSEL_BIT];
      refSupplySelect_r <= wrData[`PIN_SUPPLYSEL_BIT];
      touchPanelEnable_r <= wrData[`PIN_TOUCH_BIT];
      supplyMeasureEnable_r <= wrData[`PIN_MEAS_BIT];
      channel0GroundEnable_r <= wrData[`PIN_GND_BIT];
      halfMode_r <= wrData[`PIN_HALF_BIT];
    end
  end

  always @(posedge clk)
  begin
    if (!resetn)
    begin
      stylusIrqEnable_r <= 1'b0;
      driverEnable_r <= `RST_PINS;
      driveLevel_r <= `RST_PINS;
    end
    else if (wrPinOut)
    begin
      stylusIrqEnable_r <= wrData[`GPO_IRQEN_BIT];
      driverEnable_r <= wrData[`GPO_EN_MSB:`GPO_EN_LSB];
      driveLevel_r <= wrData[`GPO_LVL_MSB:`GPO_LVL_LSB];
    end
  end

  // Analog steering outputs follow the control bits one clock later
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      vrefFromSupply_r <= 1'b0;
      vrefFromBandgap_r <= 1'b1;
      bandgapLevel1V_r <= 1'b0;
      vrefFromPins_r <= 1'b0;
      vrefPosPin_r <= 2'h0;
      vrefNegPin_r <= 2'h0;
      supplyMeasureSwitch_r <= 1'b0;
      channel0Ground_r <= 1'b0;
      channel1Divider_r <= 1'b0;
      pinOut_r <= `RST_PINS;
      pinOe_r <= `RST_PINS;
      stylusDetectStatus_r <= 1'b0;
      stylusIrq_r <= 1'b0;
    end
    else
    begin
      vrefFromSupply_r <= !touchPanelEnable_r && refSupplySelect_r; // [RL1] [RL2]
      vrefFromBandgap_r <= !touchPanelEnable_r && !refSupplySelect_r; // [RL1] [RL2]
      bandgapLevel1V_r <= !touchPanelEnable_r && !refSupplySelect_r
        && bandgapLevelSelect_r; // [RL21]
      vrefFromPins_r <= touchPanelEnable_r && touchAxisFound; // [RL4] [RL22]
      if (touchPanelEnable_r && touchAxisFound)
      begin
        vrefPosPin_r <= posPick[1:0]; // [RL4] [RL22]
        vrefNegPin_r <= negPick[1:0]; // [RL4] [RL22]
      end
      supplyMeasureSwitch_r <= supplyMeasureEnable_r; // [RL5]
      channel0Ground_r <= channel0GroundEnable_r; // [RL7]
      channel1Divider_r <= channel0GroundEnable_r; // [RL7]
      pinOe_r <= driverEnable_r; // [RL11]
      pinOut_r <= driveLevel_r & driverEnable_r; // [RL12]
      stylusDetectStatus_r <= penDetect; // [RL9]
      stylusIrq_r <= penDetect && stylusIrqEnable_r; // [RL10]
    end
  end

  // Read port: data appears the clock after rdEn; unmapped addresses read zero
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      rdData_r <= 16'h0000;
    end
    else if (rdEn)
    begin
      rdData_r <= 16'h0000;
      case (addr)
        `ADDR_CONV_CTRL:
        begin
          rdData_r[`CTRL_START_BIT] <= conversionStart_r;
          rdData_r[`CTRL_CHANNEL_SELECT_MSB:`CTRL_CHANNEL_SELECT_LSB] <= channelSelect_r;
          rdData_r[`CTRL_MULTI_BIT] <= multiChannel_r;
          rdData_r[`CTRL_SINGLE_BIT] <= singleConv_r;
        end
        `ADDR_RESULT:
        begin
          rdData_r[`RES_BUSY_BIT] <= conversionBusy && !statusMask_r; // [RL15]
          rdData_r[`RES_CONVERTED_CHANNEL_MSB:`RES_CONVERTED_CHANNEL_LSB] <= statusMask_r ? 3'h0 : convertedChannel;
          rdData_r[`RES_DATA_MSB:0] <= conversionResult; // [RL18]
        end
        `ADDR_CLK_CTRL:
        begin
          rdData_r[`CLK_DIV_MSB:0] <= converterClockDivider_r;
        end
        `ADDR_REF_PIN:
        begin
          rdData_r[`PIN_STATUSMASK_BIT] <= statusMask_r;
          rdData_r[`PIN_BIAS_BIT] <= biasPowerUp_r;
          rdData_r[`PIN_PWR_BIT] <= analogPowerUp_r;
          rdData_r[`PIN_REFBUF_BIT] <= refBufferEnable_r;
          rdData_r[`PIN_LVSEL_BIT] <= bandgapLevelSelect_r;
          rdData_r[`PIN_SUPPLYSEL_BIT] <= refSupplySelect_r;
          rdData_r[`PIN_RSVD5_BIT] <= 1'b0; // [RL3]
          rdData_r[`PIN_TOUCH_BIT] <= touchPanelEnable_r;
          rdData_r[`PIN_MEAS_BIT] <= supplyMeasureEnable_r;
          rdData_r[`PIN_GND_BIT] <= channel0GroundEnable_r;
          rdData_r[`PIN_HALF_BIT] <= halfMode_r;
        end
        `ADDR_PIN_OUT:
        begin
          rdData_r[`GPO_STATUS_BIT] <= stylusDetectStatus_r; // [RL9]
          rdData_r[`GPO_IRQEN_BIT] <= stylusIrqEnable_r;
          rdData_r[`GPO_EN_MSB:`GPO_EN_LSB] <= driverEnable_r;
          rdData_r[`GPO_LVL_MSB:`GPO_LVL_LSB] <= driveLevel_r;
        end
        default:
        begin
          rdData_r <= 16'h0000;
        end
      endcase
    end
  end

endmodule // sar_adc_pin_ref_gpo_ctrl

// [rtl/sar_adc_regs.vh]
// Register addresses, field positions, reset values and timing counts of the converter control
`ifndef SAR_ADC_REGS_VH
`define SAR_ADC_REGS_VH

`define ADDR_CONV_CTRL 16'h7012
`define ADDR_RESULT 16'h7014
`define ADDR_CLK_CTRL 16'h7016
`define ADDR_REF_PIN 16'h7018
`define ADDR_PIN_OUT 16'h701A

`define CTRL_START_BIT 15
`define CTRL_CHANNEL_SELECT_MSB 14
`define CTRL_CHANNEL_SELECT_LSB 12
`define CTRL_MULTI_BIT 11
`define CTRL_SINGLE_BIT 10

`define RES_BUSY_BIT 15
`define RES_CONVERTED_CHANNEL_MSB 14
`define RES_CONVERTED_CHANNEL_LSB 12
`define RES_DATA_MSB 9

`define CLK_DIV_MSB 14

`define PIN_STATUSMASK_BIT 14
`define PIN_BIAS_BIT 13
`define PIN_PWR_BIT 12
`define PIN_REFBUF_BIT 10
`define PIN_LVSEL_BIT 9
`define PIN_SUPPLYSEL_BIT 8
`define PIN_RSVD5_BIT 5
`define PIN_TOUCH_BIT 4
`define PIN_MEAS_BIT 3
`define PIN_GND_BIT 1
`define PIN_HALF_BIT 0

`define GPO_STATUS_BIT 9
`define GPO_IRQEN_BIT 8
`define GPO_EN_MSB 7
`define GPO_EN_LSB 4
`define GPO_LVL_MSB 3
`define GPO_LVL_LSB 0

`define RST_CHANNEL_SELECT 3'h0
`define RST_CLK_DIV 15'h7FFF
`define RST_CONVERTED_CHANNEL 3'h7
`define RST_DATA 10'h000
`define RST_PINS 4'h0

`define BUSY_DELAY_TICKS 4'h3
`define SAMPLE_TICKS 4'h4
`define SAMPLE_TICKS_LONG 4'h8
`define SYS_CLK_KHZ 20000
`define SAR_CLK_MAX_KHZ 2000
`define MIN_CLK_DIV ((`SYS_CLK_KHZ + `SAR_CLK_MAX_KHZ - 1) / `SAR_CLK_MAX_KHZ - 1)

`endif

// [rtl/sar_clk_div.v]
// Converter clock tick generator: one tick every divider plus one system clocks
`include "sar_adc_regs.vh"

module sar_clk_div (
  input wire clk,
  input wire resetn,
  input wire [`CLK_DIV_MSB:0] divider,
  output reg sarTick_r
);

  reg [`CLK_DIV_MSB:0] count_r;

  always @(posedge clk)
  begin
    if (!resetn)
    begin
      count_r <= 15'h0000;
      sarTick_r <= 1'b0;
    end
    else if (count_r >= divider)
    begin
      count_r <= 15'h0000; // [RL20]
      sarTick_r <= 1'b1;
    end
    else
    begin
      count_r <= count_r + 15'h0001;
      sarTick_r <= 1'b0;
    end
  end

endmodule // sar_clk_div

// [rtl/sar_conv_seq.v]
// Conversion sequencer: start delay, sampling, ten successive approximation steps, result
`include "sar_adc_regs.vh"

module sar_conv_seq (
  input wire clk,
  input wire resetn,
  input wire sarTick,
  input wire startReq,
  input wire singleMode,
  input wire multiCh,
  input wire [2:0] channel_select,
  input wire compHigh,
  output reg busy_r,
  output reg clearStart_r,
  output reg sampling_r,
  output reg standby_r,
  output reg [2:0] activeChan_r,
  output reg [`RES_DATA_MSB:0] trial_r,
  output reg [2:0] resultChan_r,
  output reg [`RES_DATA_MSB:0] resultData_r
);

  localparam IDLE = 3'h0;
  localparam DELAY = 3'h1;
  localparam SAMPLE = 3'h2;
  localparam CONVERT = 3'h3;
  localparam FINISH = 3'h4;

  reg [2:0] state_r;
  reg [3:0] ticks_r;
  reg [`RES_DATA_MSB:0] mask_r;
  wire [`RES_DATA_MSB:0] kept = compHigh ? trial_r : (trial_r & ~mask_r);

  always @(posedge clk)
  begin
    if (!resetn)
    begin
      state_r <= IDLE;
      ticks_r <= 4'h0;
      mask_r <= 10'h000;
      trial_r <= 10'h000;
      busy_r <= 1'b0;
      clearStart_r <= 1'b0;
      sampling_r <= 1'b0;
      standby_r <= 1'b1;
      activeChan_r <= `RST_CONVERTED_CHANNEL;
      resultChan_r <= `RST_CONVERTED_CHANNEL;
      resultData_r <= `RST_DATA;
    end
    else
    begin
      clearStart_r <= 1'b0;
      case (state_r)
        IDLE:
        begin
          if (startReq)
          begin
            state_r <= DELAY;
            standby_r <= 1'b0;
            ticks_r <= 4'h0;
            activeChan_r <= channel_select;
          end
        end
        DELAY:
        begin
          if (!startReq)
          begin
            state_r <= IDLE;
            standby_r <= 1'b1;
          end
          else if (sarTick)
          begin
            if (ticks_r == `BUSY_DELAY_TICKS - 4'h1)
            begin
              busy_r <= 1'b1; // [RL15] [RL19]
              sampling_r <= 1'b1;
              ticks_r <= 4'h0;
              state_r <= SAMPLE;
            end
            else
            begin
              ticks_r <= ticks_r + 4'h1;
            end
          end
        end
        SAMPLE:
        begin
          if (sarTick)
          begin
            if (ticks_r == (multiCh ? `SAMPLE_TICKS_LONG : `SAMPLE_TICKS) - 4'h1)
            begin
              sampling_r <= 1'b0;
              mask_r <= 10'h200;
              trial_r <= 10'h200;
              state_r <= CONVERT;
            end
            else
            begin
              ticks_r <= ticks_r + 4'h1;
            end
          end
        end
        CONVERT:
        begin
          if (sarTick)
          begin
            mask_r <= mask_r >> 1;
            trial_r <= kept | (mask_r >> 1);
            if (mask_r == 10'h001)
            begin
              resultData_r <= kept; // [RL18]
              resultChan_r <= activeChan_r;
              state_r <= FINISH;
            end
          end
        end
        FINISH:
        begin
          busy_r <= 1'b0; // [RL17]
          ticks_r <= 4'h0;
          if (singleMode || !startReq)
          begin
            clearStart_r <= singleMode;
            standby_r <= 1'b1;
            state_r <= IDLE;
          end
          else
          begin
            activeChan_r <= channel_select;
            state_r <= DELAY;
          end
        end
        default:
        begin
          state_r <= IDLE;
          busy_r <= 1'b0;
          sampling_r <= 1'b0;
          standby_r <= 1'b1;
        end
      endcase
    end
  end

endmodule // sar_conv_seq

// [tb/analog_model.sv]
// Behavioural analog side: sampled input against the trial code, pen contact
module analog_model (
  input wire clk,
  input wire [9:0] level,
  input wire penIn,
  input wire sampleEnable,
  input wire halfArraySample,
  input wire [9:0] trialCode,
  output logic compHigh,
  output logic penDetect
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [9:0] held = 10'h000;
  always @(posedge clk)
  begin
    if (sampleEnable)
      held <= halfArraySample ? {1'b0, level[9:1]} : level;
  end
  assign compHigh = held >= trialCode;
  assign penDetect = penIn;
endmodule // analog_model

// [tb/sar_adc_sva.sv]
// Port-level assertions for the converter control top
`include "sar_adc_regs.vh"
module sar_adc_sva (
  input wire clk,
  input wire resetn,
  input wire [15:0] addr,
  input wire wrEn,
  input wire [15:0] wrData,
  input wire penDetect,
  input wire sampleEnable,
  input wire halfArraySample,
  input wire converterStandby,
  input wire vrefFromSupply_r,
  input wire vrefFromBandgap_r,
  input wire bandgapLevel1V_r,
  input wire vrefFromPins_r,
  input wire [1:0] vrefPosPin_r,
  input wire [1:0] vrefNegPin_r,
  input wire supplyMeasureSwitch_r,
  input wire channel0Ground_r,
  input wire channel1Divider_r,
  input wire [3:0] pinOut_r,
  input wire [3:0] pinOe_r,
  input wire stylusIrq_r
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  wire gpoWr = wrEn && addr == `ADDR_PIN_OUT;
  wire refWr = wrEn && addr == `ADDR_REF_PIN;
  property p_oe; gpoWr |-> ##2 pinOe_r == $past(wrData[7:4], 2); endproperty
  a_oe: assert property (p_oe) else $error("driver enable mismatch");
  property p_lvl; gpoWr |-> ##2 pinOut_r == ($past(wrData[3:0], 2) & $past(wrData[7:4], 2));
  endproperty
  a_lvl: assert property (p_lvl) else $error("pin level mismatch");
  property p_irq; stylusIrq_r |-> $past(penDetect); endproperty
  a_irq: assert property (p_irq) else $error("irq without pen");
  property p_irqoff; gpoWr && !wrData[8] |-> ##2 !stylusIrq_r; endproperty
  a_irqoff: assert property (p_irqoff) else $error("irq not suppressed");
  property p_meas; refWr |-> ##2 supplyMeasureSwitch_r == $past(wrData[3], 2); endproperty
  a_meas: assert property (p_meas) else $error("supply switch mismatch");
  property p_gnd; refWr |-> ##2 channel0Ground_r == $past(wrData[1], 2)
    && channel1Divider_r == $past(wrData[1], 2); endproperty
  a_gnd: assert property (p_gnd) else $error("ground switch mismatch");
  property p_ref; refWr && !wrData[4] |-> ##2 vrefFromSupply_r == $past(wrData[8], 2)
    && vrefFromBandgap_r == !$past(wrData[8], 2)
    && ($past(wrData[8], 2) || bandgapLevel1V_r == $past(wrData[9], 2)); endproperty
  a_ref: assert property (p_ref) else $error("reference select mismatch");
  property p_touch; refWr && wrData[4] |-> ##2 !vrefFromSupply_r; endproperty
  a_touch: assert property (p_touch) else $error("supply ref in touch mode");
  property p_pins; vrefFromPins_r |-> pinOe_r[vrefPosPin_r] && pinOut_r[vrefPosPin_r]
    && pinOe_r[vrefNegPin_r] && !pinOut_r[vrefNegPin_r]; endproperty
  a_pins: assert property (p_pins) else $error("touch refs off drive pair");
  property p_half; halfArraySample |-> sampleEnable && !converterStandby; endproperty
  a_half: assert property (p_half) else $error("half sample outside sampling");
endmodule // sar_adc_sva

bind sar_adc_pin_ref_gpo_ctrl sar_adc_sva sar_adc_sva_inst (.clk, .resetn, .addr, .wrEn,
  .wrData, .penDetect, .sampleEnable, .halfArraySample, .converterStandby, .vrefFromSupply_r,
  .vrefFromBandgap_r, .bandgapLevel1V_r, .vrefFromPins_r, .vrefPosPin_r, .vrefNegPin_r,
  .supplyMeasureSwitch_r, .channel0Ground_r, .channel1Divider_r, .pinOut_r, .pinOe_r,
  .stylusIrq_r);

// [tb/tb.sv]
// Self-checking bench for the converter control block
`include "sar_adc_regs.vh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [15:0] wrData = 16'h0000;
  logic wrEn = 1'b0;
  logic rdEn = 1'b0;
  logic [9:0] level = 10'h2A5;
  logic penIn = 1'b0;
  int err_count = 0;
  int tests_run = 0;
  wire [15:0] rdData_r;
  wire [9:0] trialCode;
  wire [1:0] vrefPosPin_r, vrefNegPin_r;
  wire [3:0] pinOut_r, pinOe_r;
  wire compHigh, penDetect, sarTick, converterStandby, sampleEnable, halfArraySample;
  wire vrefFromSupply_r, vrefFromBandgap_r, bandgapLevel1V_r, vrefFromPins_r;
  wire supplyMeasureSwitch_r, channel0Ground_r, channel1Divider_r, stylusIrq_r, clkDivTooFast;
  wire [2:0] muxChannel;
  wire muxChannelValid, biasPowerUp_r, analogPowerUp_r, refBufferEnable_r;
  sar_adc_pin_ref_gpo_ctrl sar_adc_pin_ref_gpo_ctrl_inst (.clk, .resetn, .addr, .wrEn, .rdEn,
    .wrData, .rdData_r, .compHigh, .penDetect, .sarTick, .converterStandby, .sampleEnable,
    .halfArraySample, .muxChannel, .muxChannelValid, .trialCode, .vrefFromSupply_r,
    .vrefFromBandgap_r, .bandgapLevel1V_r, .vrefFromPins_r, .vrefPosPin_r, .vrefNegPin_r,
    .supplyMeasureSwitch_r, .channel0Ground_r, .channel1Divider_r, .biasPowerUp_r,
    .analogPowerUp_r, .refBufferEnable_r, .pinOut_r, .pinOe_r, .stylusIrq_r,
    .clkDivTooFast);
  analog_model analog_model_inst (.clk, .level, .penIn, .sampleEnable, .halfArraySample,
    .trialCode, .compHigh, .penDetect);
  always #25 clk = ~clk;

  task automatic complete_run;
  begin
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
  begin
    tests_run++;
    if (got !== exp)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  end
  endtask

  // Write, then let the steering outputs settle
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
  begin
    @(posedge clk);
    #5;
    addr = a;
    wrData = d;
    wrEn = 1'b1;
    @(posedge clk);
    #5;
    wrEn = 1'b0;
    @(posedge clk);
    #5;
  end
  endtask

  task automatic rd(input logic [15:0] a, output logic [15:0] d);
  begin
    @(posedge clk);
    #5;
    addr = a;
    rdEn = 1'b1;
    @(posedge clk);
    #5;
    rdEn = 1'b0;
    d = rdData_r;
  end
  endtask

  task automatic rdc(input logic [15:0] a, input logic [15:0] exp);
    logic [15:0] d;
  begin
    rd(a, d);
    chk(d, exp);
  end
  endtask

  task automatic t_reset;
  begin
    rdc(`ADDR_CLK_CTRL, 16'h7FFF);
    rdc(`ADDR_RESULT, 16'h7000);
    rdc(`ADDR_REF_PIN, 16'h0000);
    rdc(`ADDR_PIN_OUT, 16'h0000);
    rdc(16'h7010, 16'h0000);
    chk({15'h0, vrefFromBandgap_r}, 16'h0001);
  end
  endtask

  task automatic t_gpo;
    logic [7:0] i;
  begin
    for (int n = 0; n < 256; n++)
    begin
      i = n[7:0];
      wr(`ADDR_PIN_OUT, {8'h00, i});
      chk({8'h00, pinOe_r, pinOut_r}, {8'h00, i[7:4], i[7:4] & i[3:0]});
      rdc(`ADDR_PIN_OUT, {8'h00, i});
    end
  end
  endtask

  task automatic t_ref;
    logic [3:0] i;
    logic [15:0] d;
  begin
    for (int n = 0; n < 16; n++)
    begin
      i = n[3:0];
      d = {6'h00, i[3], i[2], 4'h0, i[1], 1'b0, i[0], 1'b0};
      wr(`ADDR_REF_PIN, d);
      chk({10'h000, vrefFromSupply_r, vrefFromBandgap_r, supplyMeasureSwitch_r,
        channel0Ground_r, channel1Divider_r, i[2] ? 1'b0 : bandgapLevel1V_r},
        {10'h000, i[2], !i[2], i[1], i[0], i[0], i[2] ? 1'b0 : i[3]});
      rdc(`ADDR_REF_PIN, d);
    end
  end
  endtask

  task automatic t_touch;
  begin
    wr(`ADDR_PIN_OUT, 16'h0031);
    wr(`ADDR_REF_PIN, 16'h0110);
    chk({10'h000, vrefFromPins_r, vrefFromSupply_r, vrefPosPin_r, vrefNegPin_r},
      16'h0021);
    wr(`ADDR_PIN_OUT, 16'h0032);
    chk({10'h000, vrefFromPins_r, vrefFromSupply_r, vrefPosPin_r, vrefNegPin_r},
      16'h0024);
    wr(`ADDR_REF_PIN, 16'h0000);
    wr(`ADDR_PIN_OUT, 16'h0000);
  end
  endtask

  task automatic t_pen;
  begin
    penIn = 1'b1;
    wr(`ADDR_PIN_OUT, 16'h0000);
    chk({15'h0, stylusIrq_r}, 16'h0000);
    rdc(`ADDR_PIN_OUT, 16'h0200);
    wr(`ADDR_PIN_OUT, 16'h0100);
    chk({15'h0, stylusIrq_r}, 16'h0001);
    penIn = 1'b0;
    wr(`ADDR_PIN_OUT, 16'h0100);
    chk({15'h0, stylusIrq_r}, 16'h0000);
    rdc(`ADDR_PIN_OUT, 16'h0100);
  end
  endtask

  task automatic t_div(input logic [15:0] div);
    int n;
  begin
    wr(`ADDR_CLK_CTRL, div);
    n = 0;
    while (sarTick !== 1'b1 && n < 99)
    begin
      @(posedge clk);
      #5;
      n++;
    end
    n = 0;
    do
    begin
      @(posedge clk);
      #5;
      n++;
    end while (sarTick !== 1'b1 && n < 99);
    chk(n[15:0], div + 16'h0001);
    chk({15'h0, clkDivTooFast}, {15'h0, div < 16'h0009});
  end
  endtask

  // Single conversion on channel 2 at 2MHz; h sets halving and the multi bit, which selects long sampling
  task automatic t_conv(input logic h, input logic [9:0] exp);
    logic [15:0] d;
    int k;
    int n;
  begin
    wr(`ADDR_REF_PIN, {12'h360, h, 2'b00, h});
    chk({13'h0, biasPowerUp_r, analogPowerUp_r, refBufferEnable_r}, 16'h0007);
    @(posedge clk);
    #5;
    addr = `ADDR_CONV_CTRL;
    wrData = {4'hA, h, 11'h400};
    wrEn = 1'b1;
    k = 0;
    n = 0;
    do
    begin
      @(posedge clk);
      #5;
      wrEn = 1'b0;
      k += (sarTick === 1'b1);
      n++;
    end while (sampleEnable !== 1'b1 && n < 300);
    chk({15'h0, k == 3 || k == 4}, 16'h0001);
    rd(`ADDR_RESULT, d);
    chk({15'h0, d[15]}, 16'h0001);
    n = 0;
    do
    begin
      rd(`ADDR_RESULT, d);
      n++;
    end while (d[15] !== 1'b0 && n < 400);
    chk(d, {6'h08, exp});
    rdc(`ADDR_CONV_CTRL, {4'h2, h, 11'h400});
    chk({15'h0, converterStandby}, 16'h0001);
    wr(`ADDR_REF_PIN, 16'h4000);
    rdc(`ADDR_RESULT, {6'h00, exp});
  end
  endtask

  // Back-to-back conversions on channel 1 until software clears start
  task automatic t_cont;
    logic [15:0] d;
    logic prev;
    int k;
    int n;
  begin
    wr(`ADDR_REF_PIN, 16'h3600);
    wr(`ADDR_CONV_CTRL, 16'h9000);
    prev = 1'b0;
    k = 0;
    n = 0;
    do
    begin
      @(posedge clk);
      #5;
      k += (sampleEnable === 1'b1 && prev === 1'b0);
      prev = sampleEnable;
      n++;
    end while (k < 2 && n < 900);
    chk(k[15:0], 16'h0002);
    chk({12'h000, muxChannelValid, muxChannel}, 16'h0009);
    wr(`ADDR_CONV_CTRL, 16'h1000);
    n = 0;
    do
    begin
      rd(`ADDR_RESULT, d);
      n++;
    end while (d[15] !== 1'b0 && n < 400);
    chk(d, {6'h04, 10'h2A5});
    rdc(`ADDR_CONV_CTRL, 16'h1000);
    chk({15'h0, converterStandby}, 16'h0001);
  end
  endtask

  initial
  begin
    repeat (20) @(posedge clk);
    #5;
    resetn = 1'b1;
    t_reset();
    t_gpo();
    t_ref();
    t_touch();
    t_pen();
    t_div(16'h0004);
    t_div(16'h0009);
    t_conv(1'b0, 10'h2A5);
    t_conv(1'b1, 10'h152);
    t_cont();
    complete_run();
  end

  initial
  begin
    #1000000;
    err_count++;
    complete_run();
  end
endmodule // tb
